// File: rtl/dcf_pkg.sv
package dcf_pkg;

  // ----------------------------------------------------------------
  // widths and depth
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 9;
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned PTR_W  = ADDR_W + 1;
  localparam int unsigned OFF_W  = 2 * DATA_W;
  localparam logic [PTR_W-1:0] DEPTH     = 19'h40000;
  localparam logic [PTR_W-1:0] HALF_CAP  = 19'h20000;
  localparam logic [PTR_W-1:0] PTR_RESET = 19'h00000;

  // ----------------------------------------------------------------
  // default offsets, picked by the load pin during full reset
  // ----------------------------------------------------------------
  localparam logic [OFF_W-1:0] OFF_DEF_SHORT = 18'h0007f;
  localparam logic [OFF_W-1:0] OFF_DEF_LONG  = 18'h003ff;

  // ----------------------------------------------------------------
  // offset word slots for parallel access
  // ----------------------------------------------------------------
  localparam logic [1:0] SLOT_EMPTY_LO = 2'h0;
  localparam logic [1:0] SLOT_EMPTY_HI = 2'h1;
  localparam logic [1:0] SLOT_FULL_LO  = 2'h2;
  localparam logic [1:0] SLOT_FULL_HI  = 2'h3;

  // ----------------------------------------------------------------
  // timing and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]        FALL_LAT   = 2'h3;
  localparam logic [DATA_W-1:0] DOUT_RESET = 9'h000;

  typedef enum logic [1:0] {
    DCF_SLOT_RESET = 2'b00
  } dcf_slot_t;

endpackage : dcf_pkg

// File: rtl/dcf_ram.sv
`timescale 1ns/10ps
`default_nettype none

module dcf_ram (
  input  wire logic                             core_clk_in,  // clock
  input  wire logic                             wr_en_in,     // write this cycle
  input  wire logic [dcf_pkg::ADDR_W-1:0]       wr_addr_in,   // write location
  input  wire logic [dcf_pkg::DATA_W-1:0]       wr_data_in,   // write word
  input  wire logic [dcf_pkg::ADDR_W-1:0]       rd_addr_in,   // read location
  output logic      [dcf_pkg::DATA_W-1:0]       rd_data_out   // word at read location
);

  // ----------------------------------------------------------------
  // storage, no reset: contents are only valid behind the pointers
  // ----------------------------------------------------------------
  logic [dcf_pkg::DATA_W-1:0] mem [0:(1 << dcf_pkg::ADDR_W)-1];

  always_ff @(posedge core_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  assign rd_data_out = mem[rd_addr_in];

endmodule : dcf_ram

`default_nettype wire

// File: rtl/dcf_fifo.sv
// What this block does
// - write data and read data are nine bits wide.
// - either reset zeroes both pointers and the output register.
// - full reset latches timing mode, default offset and load method.
// - partial reset keeps mode, method and both offsets.
// - reread request zeroes read pointer, shows empty briefly, keeps the rest.
// - mode pin picks mode in full reset, later it is serial input.
// - enabled write stores the word, or an offset word in parallel load.
// - serial method shifts one offset bit per enabled write edge.
// - enabled read delivers next word, or offset word when access pin low.
// - output enable decides whether read data lines are driven.
// - in full reset the load pin picks 127 or 1023 and the method.
// - after full reset the load pin steers accesses to offset registers.
// - full flag in standard mode, input-ready in fall-through mode.
// - empty flag in standard mode, output-ready in fall-through mode.
// - almost-full low when count exceeds capacity minus full offset.
// - almost-empty low when count is below empty offset.
// - half-full shows whether count exceeds half the capacity.
// - fall-through shows the first word after three read edges.
// - short default pairs with parallel, long default with serial.
`timescale 1ns/10ps
`default_nettype none

module dcf_fifo (
  input  wire logic                       core_clk_in,                // clock
  input  wire logic                       rstn_in,                    // chip reset, low
  input  wire logic                       full_reset_n_in,            // full reset, low
  input  wire logic                       partial_reset_n_in,         // partial reset, low
  input  wire logic                       write_clk_en_in,            // write port edge
  input  wire logic                       write_enable_n_in,          // write enable, low
  input  wire logic [dcf_pkg::DATA_W-1:0] write_data_in,              // write word
  input  wire logic                       read_clk_en_in,             // read port edge
  input  wire logic                       read_enable_n_in,           // read enable, low
  input  wire logic                       reread_from_start_n_in,     // reread, low
  input  wire logic                       output_enable_n_in,         // drive data, low
  input  wire logic                       serial_load_enable_n_in,    // serial enable, low
  input  wire logic                       offset_access_n_in,         // offset access, low
  input  wire logic                       fallthrough_sel_serial_in,  // mode / serial bit
  input  wire logic                       static_tie_input_in,        // held constant
  output logic      [dcf_pkg::DATA_W-1:0] read_data_out,              // output register
  output logic                            read_data_drive_n_out,      // low while driven
  output logic                            full_or_input_ready_out,    // full / in ready
  output logic                            empty_or_output_ready_out,  // empty / out ready
  output logic                            almost_full_n_out,          // almost full, low
  output logic                            almost_empty_n_out,         // almost empty, low
  output logic                            half_full_n_out             // half full, low
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                       fallthrough_mode;
    logic                       serial_method;
    logic [dcf_pkg::OFF_W-1:0]  full_off;
    logic [dcf_pkg::OFF_W-1:0]  empty_off;
    logic [dcf_pkg::PTR_W-1:0]  wptr;
    logic [dcf_pkg::PTR_W-1:0]  rptr;
    logic [dcf_pkg::DATA_W-1:0] dout;
    logic                       dout_valid;
    logic [1:0]                 wr_slot;
    logic [1:0]                 rd_slot;
    logic [1:0]                 lat;
    logic                       reread_hold;
  } dcf_state_t;

  dcf_state_t state_q;
  dcf_state_t state_d;

  logic [dcf_pkg::DATA_W-1:0] ram_rd_data;
  logic                       ram_we;
  logic [dcf_pkg::PTR_W-1:0]  count;
  logic                       mem_full;
  logic                       mem_empty;
  logic                       do_read;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [dcf_pkg::DATA_W-1:0] off_word(
    input logic [1:0]                slot,
    input logic [dcf_pkg::OFF_W-1:0] e_off,
    input logic [dcf_pkg::OFF_W-1:0] f_off
  );
    logic [dcf_pkg::DATA_W-1:0] w;
    case (slot)
      dcf_pkg::SLOT_EMPTY_LO: w = e_off[dcf_pkg::DATA_W-1:0];
      dcf_pkg::SLOT_EMPTY_HI: w = e_off[dcf_pkg::OFF_W-1:dcf_pkg::DATA_W];
      dcf_pkg::SLOT_FULL_LO:  w = f_off[dcf_pkg::DATA_W-1:0];
      default:                w = f_off[dcf_pkg::OFF_W-1:dcf_pkg::DATA_W];
    endcase
    return w;
  endfunction : off_word

  // ----------------------------------------------------------------
  // storage and occupancy
  // ----------------------------------------------------------------
  // single clock, so the pointers are compared directly without crossing
  assign count     = state_q.wptr - state_q.rptr;
  assign mem_full  = (count == dcf_pkg::DEPTH);
  assign mem_empty = (count == dcf_pkg::PTR_RESET);

  assign ram_we = write_clk_en_in && !write_enable_n_in && offset_access_n_in
                  && !mem_full && full_reset_n_in && partial_reset_n_in && rstn_in;

  dcf_ram u_ram (
    .core_clk_in (core_clk_in),
    .wr_en_in    (ram_we),
    .wr_addr_in  (state_q.wptr[dcf_pkg::ADDR_W-1:0]),
    .wr_data_in  (write_data_in),
    .rd_addr_in  (state_q.rptr[dcf_pkg::ADDR_W-1:0]),
    .rd_data_out (ram_rd_data)
  );

  assign do_read = read_clk_en_in && !read_enable_n_in;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;

    // write port
    if (write_clk_en_in) begin
      if (!offset_access_n_in) begin
        if (!state_q.serial_method && !write_enable_n_in) begin
          case (state_q.wr_slot)
            dcf_pkg::SLOT_EMPTY_LO: state_d.empty_off[dcf_pkg::DATA_W-1:0] = write_data_in;
            dcf_pkg::SLOT_EMPTY_HI:
              state_d.empty_off[dcf_pkg::OFF_W-1:dcf_pkg::DATA_W] = write_data_in;
            dcf_pkg::SLOT_FULL_LO:  state_d.full_off[dcf_pkg::DATA_W-1:0] = write_data_in;
            default: state_d.full_off[dcf_pkg::OFF_W-1:dcf_pkg::DATA_W] = write_data_in;
          endcase
          state_d.wr_slot = state_q.wr_slot + 2'h1;
        end
        if (state_q.serial_method && !serial_load_enable_n_in) begin
          // first bit shifted lands at the empty offset's low end after 36 edges
          {state_d.full_off, state_d.empty_off} =
            {fallthrough_sel_serial_in, state_q.full_off, state_q.empty_off[dcf_pkg::OFF_W-1:1]};
        end
      end else if (!write_enable_n_in && !mem_full) begin
        state_d.wptr = state_q.wptr + 19'h00001;
      end
    end

    // read port
    if (read_clk_en_in) begin
      state_d.reread_hold = 1'b0;
      if (!reread_from_start_n_in) begin
        state_d.rptr        = dcf_pkg::PTR_RESET;
        state_d.dout_valid  = 1'b0;
        state_d.lat         = 2'h0;
        state_d.reread_hold = 1'b1;
      end else if (!offset_access_n_in) begin
        if (do_read) begin
          state_d.dout    = off_word(state_q.rd_slot, state_q.empty_off, state_q.full_off);
          state_d.rd_slot = state_q.rd_slot + 2'h1;
        end
      end else if (!state_q.fallthrough_mode) begin
        // the reread hold shows empty, so a read during it is dropped like one when empty
        if (do_read && !mem_empty && !state_q.reread_hold) begin
          state_d.dout = ram_rd_data;
          state_d.rptr = state_q.rptr + 19'h00001;
        end
      end else if (state_q.dout_valid) begin
        if (do_read) begin
          state_d.dout_valid = !mem_empty;
          if (!mem_empty) begin
            state_d.dout = ram_rd_data;
            state_d.rptr = state_q.rptr + 19'h00001;
          end
        end
      end else if (!mem_empty) begin
        // word falls through on the third read edge without read enable
        if (state_q.lat == dcf_pkg::FALL_LAT - 2'h1) begin
          state_d.dout       = ram_rd_data;
          state_d.dout_valid = 1'b1;
          state_d.rptr       = state_q.rptr + 19'h00001;
          state_d.lat        = 2'h0;
        end else begin
          state_d.lat = state_q.lat + 2'h1;
        end
      end
    end

    // resets: partial keeps the configuration, full reloads it from pins
    if (!partial_reset_n_in || !full_reset_n_in) begin
      state_d.wptr        = dcf_pkg::PTR_RESET;
      state_d.rptr        = dcf_pkg::PTR_RESET;
      state_d.dout        = dcf_pkg::DOUT_RESET;
      state_d.dout_valid  = 1'b0;
      state_d.lat         = 2'h0;
      state_d.reread_hold = 1'b0;
      state_d.wr_slot     = dcf_pkg::DCF_SLOT_RESET;
      state_d.rd_slot     = dcf_pkg::DCF_SLOT_RESET;
    end
    if (!full_reset_n_in) begin
      state_d.fallthrough_mode = fallthrough_sel_serial_in;
      state_d.serial_method    = offset_access_n_in;
      state_d.empty_off        = offset_access_n_in ? dcf_pkg::OFF_DEF_LONG
                                                    : dcf_pkg::OFF_DEF_SHORT;
      state_d.full_off         = state_d.empty_off;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      state_q <= '{fallthrough_mode: 1'b0, serial_method: 1'b0,
                   full_off: dcf_pkg::OFF_DEF_SHORT, empty_off: dcf_pkg::OFF_DEF_SHORT,
                   wptr: dcf_pkg::PTR_RESET, rptr: dcf_pkg::PTR_RESET,
                   dout: dcf_pkg::DOUT_RESET, dout_valid: 1'b0,
                   wr_slot: dcf_pkg::DCF_SLOT_RESET, rd_slot: dcf_pkg::DCF_SLOT_RESET,
                   lat: 2'h0, reread_hold: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the tie input carries no function; its level is the outside's business
  assign read_data_out         = state_q.dout;
  assign read_data_drive_n_out = output_enable_n_in;

  // standard: low means full; fall-through: low means room to write
  assign full_or_input_ready_out = state_q.fallthrough_mode ? mem_full : !mem_full;
  // standard: low means empty; fall-through: low means word presented
  assign empty_or_output_ready_out = state_q.fallthrough_mode
                                     ? (!state_q.dout_valid || state_q.reread_hold)
                                     : (!mem_empty && !state_q.reread_hold);

  assign almost_full_n_out  = !(count > (dcf_pkg::DEPTH
                                         - {1'b0, state_q.full_off}));
  assign almost_empty_n_out = !(count < {1'b0, state_q.empty_off});
  assign half_full_n_out    = !(count > dcf_pkg::HALF_CAP);

endmodule : dcf_fifo

`default_nettype wire

// File: verification/dcf_port_model.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// far-side writer and reader port edges
// ------------------------------------------------------------
module dcf_port_model (
  input  wire logic core_clk_in,       // clock
  input  wire logic rstn_in,           // reset, low
  input  wire logic slow_in,           // edge every other cycle
  output logic      write_clk_en_out,  // write port edge
  output logic      read_clk_en_out,   // read port edge
  output logic      static_tie_out     // held level
);
  logic ph_q;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      ph_q <= 1'b0;
    end else begin
      ph_q <= !ph_q;
    end
  end

  // slow mode makes the bench hold requests across idle edges
  assign write_clk_en_out = slow_in ? ph_q : 1'b1;
  assign read_clk_en_out  = slow_in ? !ph_q : 1'b1;
  assign static_tie_out   = 1'b0;
endmodule : dcf_port_model

`default_nettype wire

// File: verification/dcf_fifo_props.sv
`timescale 1ns/10ps
`default_nettype none

module dcf_fifo_props (
  input wire logic                       core_clk_in,                // clk
  input wire logic                       rstn_in,                    // rst
  input wire logic                       full_reset_n_in,            // full rst
  input wire logic                       partial_reset_n_in,         // part rst
  input wire logic                       write_clk_en_in,            // wr edge
  input wire logic                       write_enable_n_in,          // wr en
  input wire logic                       read_clk_en_in,             // rd edge
  input wire logic                       read_enable_n_in,           // rd en
  input wire logic                       reread_from_start_n_in,     // reread
  input wire logic                       output_enable_n_in,         // oe
  input wire logic                       offset_access_n_in,         // load pin
  input wire logic                       fallthrough_sel_serial_in,  // mode
  input wire logic [dcf_pkg::DATA_W-1:0] read_data_out,              // data
  input wire logic                       read_data_drive_n_out,      // drive
  input wire logic                       full_or_input_ready_out,    // full
  input wire logic                       empty_or_output_ready_out,  // empty
  input wire logic                       almost_full_n_out,          // af
  input wire logic                       almost_empty_n_out,         // ae
  input wire logic                       half_full_n_out             // hf
);
  logic fw_q;
  logic live;

  // mode as latched by the last full reset
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      fw_q <= 1'b0;
    end else if (!full_reset_n_in) begin
      fw_q <= fallthrough_sel_serial_in;
    end
  end
  assign live = full_reset_n_in && partial_reset_n_in;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  property p_oe; read_data_drive_n_out == output_enable_n_in; endproperty
  a_oe: assert property (p_oe) else $error("drive follows oe");
  property p_frs_data; !full_reset_n_in |=> read_data_out == dcf_pkg::DOUT_RESET; endproperty
  a_frs_data: assert property (p_frs_data) else $error("data after full reset");
  property p_prs; !partial_reset_n_in |=> read_data_out == '0 && half_full_n_out
    && almost_full_n_out; endproperty
  a_prs: assert property (p_prs) else $error("state after partial reset");
  property p_frs_mode; !full_reset_n_in |=> empty_or_output_ready_out == fw_q
    && full_or_input_ready_out == !fw_q; endproperty
  a_frs_mode: assert property (p_frs_mode) else $error("flags after full reset");
  property p_frs_ae; !full_reset_n_in ##1 1'b1 |-> !almost_empty_n_out; endproperty
  a_frs_ae: assert property (p_frs_ae) else $error("almost empty after reset");
  property p_prs_mode; live ##1 !partial_reset_n_in && full_reset_n_in
    |=> empty_or_output_ready_out == fw_q; endproperty
  a_prs_mode: assert property (p_prs_mode) else $error("mode lost");
  property p_rt; live && read_clk_en_in && !reread_from_start_n_in
    |=> empty_or_output_ready_out == fw_q; endproperty
  a_rt: assert property (p_rt) else $error("reread flag");
  property p_rd_empty; live && !fw_q && !empty_or_output_ready_out && read_clk_en_in
    && !read_enable_n_in && reread_from_start_n_in && offset_access_n_in
    |=> $stable(read_data_out); endproperty
  a_rd_empty: assert property (p_rd_empty) else $error("read when empty");
  property p_wr_std; live && !fw_q && !empty_or_output_ready_out && write_clk_en_in
    && !write_enable_n_in && offset_access_n_in && read_clk_en_in && reread_from_start_n_in
    |=> empty_or_output_ready_out; endproperty
  a_wr_std: assert property (p_wr_std) else $error("write not seen");

  c_rt: cover property (live && read_clk_en_in && !reread_from_start_n_in);
  c_wr: cover property (live && !fw_q && write_clk_en_in && !write_enable_n_in);
  c_fw: cover property (fw_q && !empty_or_output_ready_out);
endmodule : dcf_fifo_props

bind dcf_fifo dcf_fifo_props chk (
  .core_clk_in               (core_clk_in),
  .rstn_in                   (rstn_in),
  .full_reset_n_in           (full_reset_n_in),
  .partial_reset_n_in        (partial_reset_n_in),
  .write_clk_en_in           (write_clk_en_in),
  .write_enable_n_in         (write_enable_n_in),
  .read_clk_en_in            (read_clk_en_in),
  .read_enable_n_in          (read_enable_n_in),
  .reread_from_start_n_in    (reread_from_start_n_in),
  .output_enable_n_in        (output_enable_n_in),
  .offset_access_n_in        (offset_access_n_in),
  .fallthrough_sel_serial_in (fallthrough_sel_serial_in),
  .read_data_out             (read_data_out),
  .read_data_drive_n_out     (read_data_drive_n_out),
  .full_or_input_ready_out   (full_or_input_ready_out),
  .empty_or_output_ready_out (empty_or_output_ready_out),
  .almost_full_n_out         (almost_full_n_out),
  .almost_empty_n_out        (almost_empty_n_out),
  .half_full_n_out           (half_full_n_out)
);

`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic core_clk_in, rstn_in, full_reset_n_in, partial_reset_n_in, write_clk_en_in;
  logic write_enable_n_in, read_clk_en_in, read_enable_n_in, reread_from_start_n_in;
  logic output_enable_n_in, serial_load_enable_n_in, offset_access_n_in, slow;
  logic fallthrough_sel_serial_in, static_tie_input_in, read_data_drive_n_out;
  logic full_or_input_ready_out, empty_or_output_ready_out, almost_full_n_out;
  logic almost_empty_n_out, half_full_n_out;
  logic [dcf_pkg::DATA_W-1:0] write_data_in, read_data_out, v;
  logic [dcf_pkg::DATA_W-1:0] ofs [4] = '{9'h005, 9'h000, 9'h003, 9'h000};
  logic [35:0] sv = 36'h000000009;
  int errors, total_checks;

  dcf_fifo uut (
    .core_clk_in               (core_clk_in),
    .rstn_in                   (rstn_in),
    .full_reset_n_in           (full_reset_n_in),
    .partial_reset_n_in        (partial_reset_n_in),
    .write_clk_en_in           (write_clk_en_in),
    .write_enable_n_in         (write_enable_n_in),
    .write_data_in             (write_data_in),
    .read_clk_en_in            (read_clk_en_in),
    .read_enable_n_in          (read_enable_n_in),
    .reread_from_start_n_in    (reread_from_start_n_in),
    .output_enable_n_in        (output_enable_n_in),
    .serial_load_enable_n_in   (serial_load_enable_n_in),
    .offset_access_n_in        (offset_access_n_in),
    .fallthrough_sel_serial_in (fallthrough_sel_serial_in),
    .static_tie_input_in       (static_tie_input_in),
    .read_data_out             (read_data_out),
    .read_data_drive_n_out     (read_data_drive_n_out),
    .full_or_input_ready_out   (full_or_input_ready_out),
    .empty_or_output_ready_out (empty_or_output_ready_out),
    .almost_full_n_out         (almost_full_n_out),
    .almost_empty_n_out        (almost_empty_n_out),
    .half_full_n_out           (half_full_n_out)
  );
  dcf_port_model far (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .slow_in(slow),
    .write_clk_en_out(write_clk_en_in), .read_clk_en_out(read_clk_en_in),
    .static_tie_out(static_tie_input_in));

  initial begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end

  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // k: 0 write, 1 read, 2 serial bit, 3 reread; held until a port edge takes it
  task automatic op(input int k, input logic [8:0] d);
    @(posedge core_clk_in);
    write_data_in             <= d;
    fallthrough_sel_serial_in <= d[0];
    case (k)
      0: write_enable_n_in <= 1'b0;
      1: read_enable_n_in <= 1'b0;
      2: serial_load_enable_n_in <= 1'b0;
      default: reread_from_start_n_in <= 1'b0;
    endcase
    do @(posedge core_clk_in); while ((k[0] ? read_clk_en_in : write_clk_en_in) !== 1'b1);
    write_enable_n_in       <= 1'b1;
    read_enable_n_in        <= 1'b1;
    serial_load_enable_n_in <= 1'b1;
    reread_from_start_n_in  <= 1'b1;
    @(negedge core_clk_in);
    v = read_data_out;
  endtask : op

  task automatic frst(input logic ld, input logic m);
    @(posedge core_clk_in);
    full_reset_n_in           <= 1'b0;
    offset_access_n_in        <= ld;
    fallthrough_sel_serial_in <= m;
    @(posedge core_clk_in);
    full_reset_n_in    <= 1'b1;
    offset_access_n_in <= 1'b1;
    @(negedge core_clk_in);
  endtask : frst

  task automatic oa(input logic a);
    @(posedge core_clk_in);
    offset_access_n_in <= a;
  endtask : oa

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge core_clk_in);
    errors++;
    stop_test();
  end

  initial begin
    {rstn_in, slow, output_enable_n_in, write_data_in, fallthrough_sel_serial_in} = '0;
    {full_reset_n_in, partial_reset_n_in, write_enable_n_in, read_enable_n_in} = '1;
    {reread_from_start_n_in, serial_load_enable_n_in, offset_access_n_in} = '1;
    {errors, total_checks} = '0;
    repeat (16) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    frst(1'b0, 1'b0);
    chk("data", 9'h000, read_data_out);
    chk("drive", 9'h000, read_data_drive_n_out);
    chk("empty", 9'h000, empty_or_output_ready_out);
    chk("full", 9'h001, full_or_input_ready_out);
    chk("almost_empty", 9'h000, almost_empty_n_out);
    chk("almost_full", 9'h001, almost_full_n_out);
    chk("half_full", 9'h001, half_full_n_out);
    oa(1'b0);
    for (int i = 0; i < 4; i++) begin
      op(1, 9'h000);
      chk("default_offset", i[0] ? 9'h000 : 9'h07f, v);
    end
    for (int i = 0; i < 4; i++) op(0, ofs[i]);
    for (int i = 0; i < 4; i++) begin
      op(1, 9'h000);
      chk("offset", ofs[i], v);
    end
    oa(1'b1);
    for (int i = 0; i < 5; i++) begin
      op(0, 9'h100 + 9'(i));
      chk("almost_empty", (i >= 4) ? 9'h001 : 9'h000, almost_empty_n_out);
    end
    slow = 1'b1;
    for (int i = 0; i < 5; i++) begin
      op(1, 9'h000);
      chk("data", 9'h100 + 9'(i), v);
    end
    op(1, 9'h000);
    chk("data", 9'h104, v);
    op(3, 9'h000);
    chk("empty", 9'h000, empty_or_output_ready_out);
    repeat (4) @(negedge core_clk_in);
    op(1, 9'h000);
    chk("data", 9'h100, v);
    slow = 1'b0;
    @(posedge core_clk_in);
    partial_reset_n_in <= 1'b0;
    @(posedge core_clk_in);
    partial_reset_n_in <= 1'b1;
    @(negedge core_clk_in);
    chk("data", 9'h000, read_data_out);
    chk("empty", 9'h000, empty_or_output_ready_out);
    oa(1'b0);
    for (int i = 0; i < 4; i++) begin
      op(1, 9'h000);
      chk("kept_offset", ofs[i], v);
    end
    oa(1'b1);
    frst(1'b1, 1'b1);
    chk("output_ready", 9'h001, empty_or_output_ready_out);
    chk("input_ready", 9'h000, full_or_input_ready_out);
    oa(1'b0);
    for (int i = 0; i < 4; i++) begin
      op(1, 9'h000);
      chk("default_offset", i[0] ? 9'h001 : 9'h1ff, v);
    end
    for (int i = 0; i < 36; i++) op(2, {8'h00, sv[i]});
    for (int i = 0; i < 4; i++) begin
      op(1, 9'h000);
      chk("serial_offset", (i == 0) ? 9'h009 : 9'h000, v);
    end
    oa(1'b1);
    op(0, 9'h0a5);
    repeat (4) @(negedge core_clk_in);
    chk("output_ready", 9'h000, empty_or_output_ready_out);
    chk("data", 9'h0a5, read_data_out);
    op(1, 9'h000);
    chk("output_ready", 9'h001, empty_or_output_ready_out);
    @(posedge core_clk_in);
    output_enable_n_in <= 1'b1;
    @(negedge core_clk_in);
    chk("drive", 9'h001, read_data_drive_n_out);
    stop_test();
  end
endmodule : testbench

`default_nettype wire
